/* File: rtl/bpc_pkg.sv */
// Shared types and constants for the bus performance counters
`default_nettype none

package bpc_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned BPC_CNT_W  = 32;
   localparam int unsigned BPC_NCH    = 4;
   localparam int unsigned BPC_NPORT  = 4;

   // ==========================================================
   // Reset values and increments
   localparam logic [31:0] BPC_CNT_RST  = 32'h0000_0000;
   localparam logic [31:0] BPC_INC_ONE  = 32'h0000_0001;
   localparam logic [31:0] BPC_INC_BR   = 32'h0000_0002;

   // ==========================================================
   // Measurement item selection per channel
   typedef enum logic [2:0]
   {
      BPC_SEL_OFF      = 3'h0,
      BPC_SEL_REQ_CELL = 3'h1,
      BPC_SEL_RSP_CELL = 3'h2,
      BPC_SEL_REQ_WAIT = 3'h3,
      BPC_SEL_RSP_WAIT = 3'h4,
      BPC_SEL_BRANCH   = 3'h5,
      BPC_SEL_CACHE    = 3'h6
   } bpc_sel_type;

   // ==========================================================
   // System bus sample, taken on a bus clock enable
   typedef struct packed
   {
      logic                 req_valid;
      logic                 rsp_valid;
      logic [BPC_NPORT-1:0] req;
      logic [BPC_NPORT-1:0] gnt;
      logic [BPC_NPORT-1:0] r_req;
      logic [BPC_NPORT-1:0] r_gnt;
   } bpc_bus_type;

   // Core-side events
   typedef struct packed
   {
      logic branch;
      logic cache_area;
      logic tb_uncached;
   } bpc_core_type;

endpackage

`default_nettype wire

/* File: rtl/bpc_counter.sv */
// One 32-bit counter slice with carry out and sticky wrap flag
`default_nettype none

module bpc_counter
   import bpc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_init,
   input  wire logic [31:0] i_inc,
   output logic      [31:0] o_value,
   output logic             o_carry,
   output logic             o_wrap
);

   logic [32:0] sum;
   logic [31:0] value_r;
   logic        wrap_r;

   // Sum with carry out of bit 31
   assign sum     = {1'b0, value_r} + {1'b0, i_inc};
   assign o_carry = sum[32];
   assign o_value = value_r;
   assign o_wrap  = wrap_r;

   // Counter and sticky flag; init clears both
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || i_init)
      begin
         value_r <= BPC_CNT_RST;
         wrap_r  <= 1'b0;
      end
      else
      begin
         value_r <= sum[31:0];
         wrap_r  <= wrap_r | sum[32];
      end
   end

endmodule

`default_nettype wire

/* File: rtl/bpc_top.sv */
// Bus performance counters: four channels watching the system bus
// What this block does
// - Request and response counters add one per bus clock cycle with a valid cell.
// - Request wait counter adds one per bus cycle with a request not yet granted.
// - Response wait counter adds one per bus cycle with a response not accepted.
// - Several simultaneous waits in one cycle still add only one.
// - A counted branch adds two to the counter.
// - Counters run on the CPU clock and stop when that clock is stopped.
// - Counters are 32 bits; with extension a pair forms one 64-bit counter.
// - Extension is selectable only on channel one and channel three.
// - Accesses left uncached by the translation buffer count as cacheable.
// - An initialize request from the host clears all results to zero.
`default_nettype none

module bpc_top
   import bpc_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_bus_tick,
   input  wire bpc_bus_type           i_bus,
   input  wire bpc_core_type          i_core,
   input  wire bpc_sel_type [3:0]     i_sel,
   input  wire logic                  i_ext_one,
   input  wire logic                  i_ext_three,
   input  wire logic                  i_init,
   output logic [BPC_NCH-1:0][31:0]   o_count,
   output logic [BPC_NCH-1:0]         o_wrap
);

   // ==========================================================
   // Event decoding
   logic                      req_wait;
   logic                      rsp_wait;
   logic                      cache_hit;
   logic [BPC_NCH-1:0][31:0]  inc;
   logic [BPC_NCH-1:0]        carry;
   logic [BPC_NCH-1:0][31:0]  val;
   logic [BPC_NCH-1:0]        wrap;
   logic [1:0]                ext;
   logic [7:0]                events;

   // Any waiting port makes one wait cycle
   assign req_wait  = |(i_bus.req & ~i_bus.gnt);
   assign rsp_wait  = |(i_bus.r_req & ~i_bus.r_gnt);
   // Translation-uncached accesses still count as cacheable area
   assign cache_hit = i_core.cache_area | i_core.tb_uncached;
   // Extension only on channels one and three
   assign ext = {i_ext_three, i_ext_one};

   // One event line per item, its bit position equal to the item code;
   // bus items are qualified by the bus tick here, so every input that
   // an increment depends on is an operand of a continuous assignment
   assign events[0] = 1'b0;
   assign events[1] = i_bus_tick & i_bus.req_valid;
   assign events[2] = i_bus_tick & i_bus.rsp_valid;
   assign events[3] = i_bus_tick & req_wait;
   assign events[4] = i_bus_tick & rsp_wait;
   assign events[5] = i_core.branch;
   assign events[6] = cache_hit;
   assign events[7] = 1'b0;

   // Increment for one channel from its selected item; the function
   // reads only its arguments, so its callers re-evaluate on any event
   function automatic logic [31:0] item_inc(input bpc_sel_type s,
                                            input logic [7:0] ev);
      logic [31:0] r;
      r = BPC_CNT_RST;
      case (s)
         BPC_SEL_REQ_CELL: r = ev[1] ?
                               BPC_INC_ONE : BPC_CNT_RST;
         BPC_SEL_RSP_CELL: r = ev[2] ?
                               BPC_INC_ONE : BPC_CNT_RST;
         BPC_SEL_REQ_WAIT: r = ev[3] ?
                               BPC_INC_ONE : BPC_CNT_RST;
         BPC_SEL_RSP_WAIT: r = ev[4] ?
                               BPC_INC_ONE : BPC_CNT_RST;
         BPC_SEL_BRANCH:   r = ev[5] ?
                               BPC_INC_BR : BPC_CNT_RST;
         BPC_SEL_CACHE:    r = ev[6] ?
                               BPC_INC_ONE : BPC_CNT_RST;
         default:          r = BPC_CNT_RST;
      endcase
      return r;
   endfunction

   // ==========================================================
   // Channel increments; upper half of a pair takes the carry
   genvar g;
   generate
      for (g = 0; g < BPC_NCH; g++)
      begin : g_ch
         if (g % 2 == 1)
         begin : g_hi
            assign inc[g] = ext[g/2] ?
               {31'h0000_0000, carry[g-1]} :
               item_inc(i_sel[g], events);
         end
         else
         begin : g_lo
            assign inc[g] = item_inc(i_sel[g], events);
         end
         // Counter slice on the CPU clock only
         bpc_counter u_cnt (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_init    (i_init),
            .i_inc     (inc[g]),
            .o_value   (val[g]),
            .o_carry   (carry[g]),
            .o_wrap    (wrap[g])
         );
      end
   endgenerate

   assign o_count = val;
   assign o_wrap  = wrap;

   // ==========================================================
   // Checks
   // The pair cascade takes several steps; they are named once here

   // Lower word of pair one at its top while a branch adds two
   sequence s_low_wraps;
      !i_init && i_ext_one && i_sel[0] == BPC_SEL_BRANCH
      && i_core.branch && o_count[0] >= 32'hFFFF_FFFE;
   endsequence

   // Upper word stepped by one, lower word restarted near zero
   sequence s_high_steps;
      o_count[1] == $past(o_count[1]) + 32'h1 && o_count[0] <= 32'h1;
   endsequence

   // Lower word of pair one too far from its top to carry out
   sequence s_low_quiet;
      !i_init && i_ext_one && o_count[0] < 32'hFFFF_FFFE;
   endsequence

   // Upper word of pair one unchanged from the cycle before
   sequence s_high_held;
      o_count[1] == $past(o_count[1]);
   endsequence

   // Initialize leaves every word and every wrap flag at zero
   a_init_clears:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         i_init |=> (o_count == '0 && o_wrap == 4'h0))
      else $error("init did not clear");

   // A valid request cell on a bus tick adds one
   a_req_cell:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && i_sel[0] == BPC_SEL_REQ_CELL && i_bus_tick
          && i_bus.req_valid)
         |=> o_count[0] == $past(o_count[0]) + 32'h1)
      else $error("request cell not counted");

   // Between bus ticks a response cell item holds still
   a_rsp_cell:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !i_ext_one && i_sel[1] == BPC_SEL_RSP_CELL
          && !i_bus_tick)
         |=> o_count[1] == $past(o_count[1]))
      else $error("counted without bus tick");

   // A valid response cell on a bus tick adds one
   a_rsp_cell_add:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !i_ext_one && i_sel[1] == BPC_SEL_RSP_CELL
          && i_bus_tick && i_bus.rsp_valid)
         |=> o_count[1] == $past(o_count[1]) + 32'h1)
      else $error("response cell not counted");

   // A waiting request on a bus tick adds one
   a_req_wait:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && i_sel[2] == BPC_SEL_REQ_WAIT && i_bus_tick
          && (i_bus.req & ~i_bus.gnt) != 4'h0)
         |=> o_count[2] == $past(o_count[2]) + 32'h1)
      else $error("request wait not by one");

   // A request wait is only counted on a bus tick
   a_wait_tick:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && i_sel[2] == BPC_SEL_REQ_WAIT && !i_bus_tick)
         |=> o_count[2] == $past(o_count[2]))
      else $error("wait counted without bus tick");

   // No response waiting on a bus tick leaves the count alone
   a_rsp_wait:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !i_ext_three && i_sel[3] == BPC_SEL_RSP_WAIT
          && i_bus_tick && (i_bus.r_req & ~i_bus.r_gnt) == 4'h0)
         |=> o_count[3] == $past(o_count[3]))
      else $error("response wait without wait");

   // A waiting response on a bus tick adds one
   a_rsp_wait_add:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !i_ext_three && i_sel[3] == BPC_SEL_RSP_WAIT
          && i_bus_tick && (i_bus.r_req & ~i_bus.r_gnt) != 4'h0)
         |=> o_count[3] == $past(o_count[3]) + 32'h1)
      else $error("response wait not by one");

   // All four ports waiting together still add only one
   a_wait_once:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && i_sel[2] == BPC_SEL_REQ_WAIT && i_bus_tick
          && (i_bus.req & ~i_bus.gnt) == 4'hF)
         |=> o_count[2] - $past(o_count[2]) == 32'h1)
      else $error("multiple waits counted");

   // A branch adds two
   a_branch_two:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && i_sel[0] == BPC_SEL_BRANCH && i_core.branch)
         |=> o_count[0] == $past(o_count[0]) + 32'h2)
      else $error("branch not by two");

   // A lower word that wraps passes one carry to its upper word
   a_cascade:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         s_low_wraps |=> s_high_steps)
      else $error("carry not passed up");

   // Without a carry an extended upper word ignores its own item
   a_upper_hold:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         s_low_quiet |=> s_high_held)
      else $error("upper word moved without carry");

   // An upper word that is not extended counts its own item
   a_upper_own:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !i_ext_three && i_sel[3] == BPC_SEL_BRANCH
          && i_core.branch)
         |=> o_count[3] == $past(o_count[3]) + 32'h2)
      else $error("unpaired upper word not counting");

   // Once set, a wrap flag stays until initialize
   a_wrap_sticky:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (o_wrap[0] && !i_init) |=> o_wrap[0])
      else $error("wrap flag dropped");

   // A word far from its top cannot raise its wrap flag
   a_wrap_quiet:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !o_wrap[0] && o_count[0] < 32'hFFFF_FFFE)
         |=> !o_wrap[0])
      else $error("wrap flag set without wrap");

   // An access left uncached by translation counts as cacheable
   a_uncached:
      assert property (@(posedge i_clk) disable iff (i_sys_rst)
         (!i_init && !i_ext_one && i_sel[1] == BPC_SEL_CACHE
          && i_core.tb_uncached)
         |=> o_count[1] == $past(o_count[1]) + 32'h1)
      else $error("uncached access missed");

endmodule

`default_nettype wire

/* File: testbench/bpc_bus_model.sv */
// System bus partner: bus clock ticks and request/response handshakes
`default_nettype none

module bpc_bus_model
   import bpc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [3:0]  i_req,
   input  wire logic        i_stall,
   output logic             o_tick,
   output var bpc_bus_type  o_bus
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Bus clock at half the CPU clock, one tick per bus cycle
   always_ff @(posedge i_clk)
      o_tick <= i_sys_rst ? 1'b0 : ~o_tick;

   // Acceptance withheld while stalled; a valid cell is an accepted one
   always_comb
   begin
      o_bus.req       = i_req;
      o_bus.r_req     = i_req;
      o_bus.gnt       = i_stall ? 4'h0 : i_req;
      o_bus.r_gnt     = i_stall ? 4'h0 : i_req;
      o_bus.req_valid = !i_stall && (i_req != 4'h0);
      o_bus.rsp_valid = !i_stall && (i_req != 4'h0);
   end
endmodule

`default_nettype wire

/* File: testbench/bpc_top_tb_top.sv */
// Self-checking bench for the bus performance counters
`default_nettype none

module bpc_top_tb_top
   import bpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                i_clk = 1'b0;
   logic                i_sys_rst = 1'b1;
   logic                i_init = 1'b0;
   logic                ext_one = 1'b0;
   logic                ext_three = 1'b0;
   logic                stall = 1'b0;
   logic [3:0]          req = 4'h0;
   bpc_core_type        core = '0;
   bpc_sel_type [3:0]   sel;
   logic                tick;
   bpc_bus_type         bus;
   logic [3:0][31:0]    cnt;
   logic [3:0]          wrap;
   int                  mismatches = 0;
   int                  cmp_count = 0;
   int                  cycles = 0;

   bpc_bus_model bus_m (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
      .i_stall(stall), .o_tick(tick), .o_bus(bus));

   bpc_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus_tick(tick),
      .i_bus(bus), .i_core(core), .i_sel(sel), .i_ext_one(ext_one),
      .i_ext_three(ext_three), .i_init(i_init), .o_count(cnt),
      .o_wrap(wrap));

   // ==========================================================
   // Clock, timeout and shared tasks
   always #12.5 i_clk = ~i_clk;

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask

   // Pulse initialize while core events may still be pending; initialize
   // wins at that edge, and the events are dropped together with it
   task automatic do_init();
      i_init = 1'b1;
      step(1);
      i_init = 1'b0;
      core = 3'h0;
      step(1);
      for (int i = 0; i < 4; i++)
         check(cnt[i], 32'h0);
      check({28'h0, wrap}, 32'h0);
   endtask

   // ==========================================================
   // Four ports waiting at once, then all accepted
   task automatic t_bus();
      int nrun;
      int nwait;
      nrun = 0;
      nwait = 0;
      do_init();
      for (int i = 0; i < 4; i++)
         sel[i] = bpc_sel_type'(i + 1);
      req = 4'hF;
      for (int c = 0; c < 20; c++)
      begin
         stall = (c < 10);
         @(negedge i_clk);
         if (tick && stall) nwait++;
         if (tick && !stall) nrun++;
         step(1);
      end
      req = 4'h0;
      step(2);
      check(cnt[0], 32'(nrun));
      check(cnt[1], 32'(nrun));
      check(cnt[2], 32'(nwait));
      check(cnt[3], 32'(nwait));
      $display("t_bus done");
   endtask

   // Branches add two; translation-uncached accesses count as cache
   // accesses on their own, then cacheable-area accesses alone
   task automatic t_core();
      do_init();
      sel[0] = BPC_SEL_BRANCH;
      sel[1] = BPC_SEL_CACHE;
      sel[2] = BPC_SEL_OFF;
      sel[3] = BPC_SEL_OFF;
      core = 3'h5;
      step(5);
      core = 3'h2;
      step(3);
      core = 3'h0;
      step(2);
      check(cnt[0], 32'hA);
      check(cnt[1], 32'h8);
      $display("t_core done");
   endtask

   // Paired counters: an extended upper word ignores its own item and
   // takes only carries; the other pair's upper word counts its own
   task automatic t_ext();
      do_init();
      ext_one = 1'b1;
      for (int i = 0; i < 4; i++)
         sel[i] = BPC_SEL_BRANCH;
      core.branch = 1'b1;
      step(3);
      check(cnt[0], 32'h6);
      check(cnt[1], 32'h0);
      check(cnt[3], 32'h6);
      ext_one = 1'b0;
      ext_three = 1'b1;
      do_init();
      core.branch = 1'b1;
      step(3);
      check(cnt[1], 32'h6);
      check(cnt[2], 32'h6);
      check(cnt[3], 32'h0);
      do_init();
      ext_three = 1'b0;
      $display("t_ext done");
   endtask

   task automatic report_and_stop();
      $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      for (int i = 0; i < 4; i++)
         sel[i] = BPC_SEL_OFF;
      step(20);
      i_sys_rst = 1'b0;
      check(cnt[0], 32'h0);
      t_bus();
      t_core();
      t_ext();
      report_and_stop();
   end
endmodule

`default_nettype wire
